/* File: tb/program_flash_model.sv */
// Behavioural program flash: answers each fetch in the same cycle and holds it for one more.
// Assumes the bridge raises the fetch strobe for one cycle per table word and two cycles per window word.
`timescale 1ns/1ps

module program_flash_model
(
    // Clock
    input wire logic mclk,
    // Fetch port
    input wire logic flashRequest,
    input wire logic [23:0] flashAddr,
    output logic [23:0] flashReadData
);
    // Upper byte all ones or all zeros, so stray execution is harmless
    function automatic logic [23:0] word(input logic [23:0] a);
        return {a[8] ? 8'hFF : 8'h00, a[15:0] ^ {a[23:16], 8'hC3}};
    endfunction

    logic pending;

    // Fetch cycle and the one after it show the word at the held address
    always @(posedge mclk)
    begin
        pending <= flashRequest;
    end

    // Otherwise the inverse, so stale data is never trusted
    always_comb
    begin
        flashReadData = (flashRequest || pending) ? word(flashAddr) : ~word(flashAddr);
    end
endmodule

/* File: tb/program_space_data_access_properties.sv */
// Checker for the program-space bridge: mapping, pacing and refusals.
// Sees only the top module's ports; mirrors the page registers itself.
`timescale 1ns/1ps

module program_space_data_access_properties
    import prog_access_pkg::*;
#(
    parameter int DATA_WIDTH = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    input wire logic [15:0] regReadData,
    // CPU side
    input wire logic cpuRequest,
    input wire logic [2:0] cpuOp,
    input wire logic [15:0] effectiveAddress,
    input wire logic isMove,
    input wire logic inRepeat,
    input wire logic repeatFirst,
    input wire logic repeatLast,
    input wire logic repeatIntExit,
    input wire logic repeatReentry,
    input wire logic cpuDone,
    input wire logic windowHit,
    input wire logic [1:0] stallCycles,
    input wire logic busy,
    // Flash side
    input wire logic flashRequest,
    input wire logic flashHighByte,
    input wire logic [23:0] flashAddr,
    input wire logic configSpace
);
    logic [7:0] tp;
    logic [7:0] wp;
    logic winEn;
    logic [1:0] ex;

    default clocking @(posedge mclk); endclocking
    default disable iff (!reset_n);

    // Mirrors follow writes, so checks never trust the design's own copy
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            tp <= 8'h00;
            wp <= 8'h00;
            winEn <= 1'b0;
        end
        else if (regWrite)
        begin
            if (regAddr == TABLE_PAGE_OFFSET)
                tp <= regWriteData[7:0];
            if (regAddr == WINDOW_PAGE_OFFSET)
                wp <= regWriteData[7:0];
            if (regAddr == CORE_CONTROL_OFFSET)
                winEn <= regWriteData[2];
        end
    end

    always_comb
    begin
        if (!inRepeat)
            ex = isMove ? 2'h1 : 2'h2;
        else if (repeatFirst || repeatLast || repeatIntExit || repeatReentry)
            ex = 2'h2;
        else
            ex = 2'h0;
    end

    sequence s_tbl_req;
        cpuRequest && !busy && cpuOp inside {3'h1, 3'h2, 3'h3, 3'h4};
    endsequence
    sequence s_win_req;
        cpuRequest && !busy && cpuOp == 3'h5 && effectiveAddress[15] && winEn;
    endsequence
    sequence s_win_long;
        !cpuDone [*3] ##1 cpuDone;
    endsequence

    a_tbl_addr: assert property (s_tbl_req |=> flashRequest && busy &&
        flashAddr == {$past(tp), $past(effectiveAddress[15:1]), 1'b0})
        else $error("table fetch address wrong");
    a_tbl_space: assert property (s_tbl_req |=> configSpace == $past(tp[7]))
        else $error("table space select wrong");
    a_tbl_done: assert property (s_tbl_req |-> ##2 cpuDone ##1 !cpuDone)
        else $error("table answer not in slot");
    a_high_path: assert property (s_tbl_req |=>
        flashHighByte == $past(cpuOp == 3'h2 || cpuOp == 3'h4))
        else $error("high byte path wrong");
    a_win_low: assert property (s_win_req |=> !flashHighByte [*2])
        else $error("window reached upper byte");
    a_win_addr: assert property (s_win_req |=> windowHit && flashRequest &&
        flashAddr == {$past(wp), $past(effectiveAddress[14:0]), 1'b0})
        else $error("window fetch address wrong");
    a_win_gate: assert property (cpuRequest && !busy && cpuOp == 3'h5 &&
        !(effectiveAddress[15] && winEn) |=> !windowHit && !flashRequest && cpuDone)
        else $error("window used while not selected");
    a_win_fetch2: assert property (s_win_req |-> ##2 flashRequest)
        else $error("second window fetch missing");
    a_win_stall: assert property (s_win_req |=> stallCycles == $past(ex))
        else $error("stall count wrong");
    a_win_short: assert property ((s_win_req and (ex != 2'h2)) |-> ##3 cpuDone)
        else $error("short window answer late");
    a_win_long: assert property ((s_win_req and (ex == 2'h2)) |=> s_win_long)
        else $error("long window answer mistimed");
    a_win_hold: assert property (busy && !windowHit && cpuRequest |=> !flashRequest)
        else $error("window not held off");
    a_reg_enable: assert property (regRead && regAddr == CORE_CONTROL_OFFSET |=>
        regReadData[2] == $past(winEn))
        else $error("enable bit readback wrong");
endmodule

bind program_space_data_access program_space_data_access_properties
    #(.DATA_WIDTH(DATA_WIDTH)) i_props (.*);

/* File: tb/program_space_data_access_tb_top.sv */
// Self-checking bench: register port, table operations, program window.
// Assumes the flash model answers each fetch in the same cycle.
`timescale 1ns/1ps

module program_space_data_access_tb_top
    import prog_access_pkg::*;
;
    logic mclk = 1'b0;
    logic reset_n = 1'b0;
    logic [15:0] regAddr, regWriteData, regReadData, effectiveAddress, cpuWriteData;
    logic [15:0] cpuReadData, flashWriteData, ea;
    logic regWrite, regRead, cpuRequest, byteMode, isMove, inRepeat, repeatFirst;
    logic repeatLast, repeatIntExit, repeatReentry, cpuDone, windowHit, busy;
    logic flashRequest, flashWrite, flashHighByte, configSpace, b, s;
    logic [2:0] cpuOp, o;
    logic [1:0] stallCycles;
    logic [23:0] flashAddr, flashReadData, w;
    logic [7:0] pg [2] = '{8'h12, 8'h93};
    logic [5:0] ctxs [8] = '{6'h20, 6'h00, 6'h10, 6'h18, 6'h14, 6'h12, 6'h11, 6'h30};
    int lats [8] = '{3, 4, 3, 4, 4, 4, 4, 3};
    int n_errors = 0;
    int tests_run = 0;

    always #10 mclk = ~mclk;

    program_space_data_access i_dut (.*);
    program_flash_model i_flash (.mclk(mclk), .flashRequest(flashRequest),
        .flashAddr(flashAddr), .flashReadData(flashReadData));

    task automatic test_done();
        $display("comparisons %0d mismatches %0d", tests_run, n_errors);
        if (n_errors == 0 && tests_run > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp)
        begin
            n_errors++;
            $display("[ERR] %0t got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic wr(input logic [15:0] a, input logic [15:0] d);
        @(posedge mclk);
        regWrite <= 1'b1;
        regAddr <= a;
        regWriteData <= d;
        @(posedge mclk);
        regWrite <= 1'b0;
    endtask

    task automatic rd(input logic [15:0] a, input logic [15:0] e);
        @(posedge mclk);
        regRead <= 1'b1;
        regAddr <= a;
        @(posedge mclk);
        regRead <= 1'b0;
        #1;
        chk(regReadData, e);
    endtask

    // Count is from the taking edge to the done pulse
    task automatic cpu(input logic [2:0] op, input logic bm, input logic [15:0] a,
        input logic [5:0] ctx, input logic [15:0] e, input int lat);
        int n;
        @(posedge mclk);
        cpuRequest <= 1'b1;
        cpuOp <= op;
        byteMode <= bm;
        effectiveAddress <= a;
        cpuWriteData <= ~a;
        {isMove, inRepeat, repeatFirst, repeatLast, repeatIntExit, repeatReentry} <= ctx;
        @(posedge mclk);
        cpuRequest <= 1'b0;
        #1;
        n = 1;
        if (op == 3'h3 || op == 3'h4)
            chk({flashWrite, flashHighByte, flashWriteData}, {1'b1, ~op[0], ~a});
        while (cpuDone !== 1'b1 && n < 8)
        begin
            @(posedge mclk);
            #1;
            n++;
        end
        if (cpuDone !== 1'b1)
        begin
            n_errors++;
            $display("[ERR] %0t no answer from bridge", $time);
            test_done();
        end
        chk(n, lat);
        chk(cpuReadData, e);
    endtask

    function automatic logic [15:0] tbl(input logic [2:0] op, input logic bm,
        input logic [23:0] wd, input logic sel);
        if (op == 3'h1)
            return !bm ? wd[15:0] : {8'h00, sel ? wd[15:8] : wd[7:0]};
        return (bm && sel) ? 16'h0000 : {8'h00, wd[23:16]};
    endfunction

    initial
    begin
        {regAddr, regWriteData, regWrite, regRead} = '0;
        {cpuRequest, cpuOp, byteMode, effectiveAddress, cpuWriteData} = '0;
        {isMove, inRepeat, repeatFirst, repeatLast, repeatIntExit, repeatReentry} = '0;
        repeat (5) @(posedge mclk);
        reset_n <= 1'b1;
        // ------------------------------------------------------------
        // Registers
        // ------------------------------------------------------------
        rd(TABLE_PAGE_OFFSET, TABLE_PAGE_RESET);
        rd(WINDOW_PAGE_OFFSET, WINDOW_PAGE_RESET);
        rd(CORE_CONTROL_OFFSET, CORE_CONTROL_RESET);
        wr(16'h0036, 16'hFFFF);
        rd(16'h0036, 16'h0000);
        wr(WINDOW_PAGE_OFFSET, 16'h12A7);
        rd(WINDOW_PAGE_OFFSET, 16'h00A7);
        wr(CORE_CONTROL_OFFSET, 16'h0024);
        rd(CORE_CONTROL_OFFSET, 16'h0024);
        // ------------------------------------------------------------
        // Table operations, window enabled; reads set the address top bit, writes use 0x0124
        // ------------------------------------------------------------
        for (int i = 0; i < 2; i++)
        begin
            wr(TABLE_PAGE_OFFSET, {8'h00, pg[i]});
            for (int k = 0; k < 8; k++)
            begin
                o = k[2] ? 3'h2 : 3'h1;
                b = k[1];
                s = k[0];
                ea = 16'hB346 | {15'h0000, s};
                w = i_flash.word({pg[i], ea[15:1], 1'b0});
                cpu(o, b, ea, 6'h00, tbl(o, b, w, s), 2);
            end
            cpu(3'h3, 1'b0, 16'h0124, 6'h00, 16'h0000, 2);
            cpu(3'h4, 1'b0, 16'h0124, 6'h00, 16'h0000, 2);
        end
        // ------------------------------------------------------------
        // Program window
        // ------------------------------------------------------------
        ea = 16'h8ACE;
        w = i_flash.word({8'hA7, ea[14:0], 1'b0});
        for (int i = 0; i < 8; i++)
            cpu(3'h5, 1'b0, ea, ctxs[i], w[15:0], lats[i]);
        w = i_flash.word({8'hA7, 15'h0000, 1'b0});
        cpu(3'h5, 1'b0, 16'h8000, 6'h00, w[15:0], 4);
        cpu(3'h5, 1'b0, 16'h7FFE, 6'h00, 16'h0000, 1);
        wr(CORE_CONTROL_OFFSET, 16'h0020);
        cpu(3'h5, 1'b0, 16'h8ACE, 6'h00, 16'h0000, 1);
        wr(CORE_CONTROL_OFFSET, 16'h0024);
        // Window request held up while a table read is busy
        @(posedge mclk);
        cpuRequest <= 1'b1;
        cpuOp <= 3'h1;
        effectiveAddress <= 16'h0346;
        @(posedge mclk);
        cpuOp <= 3'h5;
        effectiveAddress <= 16'h8ACE;
        @(posedge mclk);
        cpuRequest <= 1'b0;
        #1;
        chk({cpuDone, windowHit}, 2'b10);
        @(posedge mclk);
        #1;
        chk(flashRequest, 1'b0);
        // Second reset in mid-run clears the table page
        @(posedge mclk);
        reset_n <= 1'b0;
        repeat (2) @(posedge mclk);
        reset_n <= 1'b1;
        rd(TABLE_PAGE_OFFSET, TABLE_PAGE_RESET);
        rd(CORE_CONTROL_OFFSET, CORE_CONTROL_RESET);
        test_done();
    end
endmodule

/* File: verilog/prog_access_pkg.sv */
// Constants and register layout for the program-space data access bridge.
// Assumes a single 50 MHz instruction clock and a synchronous reset.
package prog_access_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam logic [15:0] TABLE_PAGE_OFFSET = 16'h0032;
    localparam logic [15:0] WINDOW_PAGE_OFFSET = 16'h0034;
    localparam logic [15:0] CORE_CONTROL_OFFSET = 16'h0044;
    localparam logic [15:0] TABLE_PAGE_RESET = 16'h0000;
    localparam logic [15:0] WINDOW_PAGE_RESET = 16'h0000;
    localparam logic [15:0] CORE_CONTROL_RESET = 16'h0020;
    localparam logic [15:0] CORE_CONTROL_MASK = 16'h1FFF;
    localparam int WINDOW_ENABLE_BIT = 2;
    localparam int CONFIG_SPACE_BIT = 7;

    // ------------------------------------------------------------
    // Address layout
    // ------------------------------------------------------------
    localparam int PAGE_WIDTH = 8;
    localparam int OFFSET_WIDTH = 15;
    localparam int DATA_ADDR_MSB = 15;
    localparam int PROG_ADDR_WIDTH = 24;
    localparam int PROG_WORD_WIDTH = 24;

    // ------------------------------------------------------------
    // Operations and extra-cycle counts
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        OP_NONE,
        OP_TABLE_READ_LOW,
        OP_TABLE_READ_HIGH,
        OP_TABLE_WRITE_LOW,
        OP_TABLE_WRITE_HIGH,
        OP_DATA_READ
    } op_e;

    localparam logic [1:0] EXTRA_MOVE = 2'h1;
    localparam logic [1:0] EXTRA_OTHER = 2'h2;
    localparam logic [1:0] EXTRA_NONE = 2'h0;

endpackage

/* File: verilog/program_space_data_access.sv */
// Bridge that lets the CPU data path read program memory as data,
// by table operations or through the program window.
// Assumes a flash array answering a fetch in the same cycle as the request.
`timescale 1ns/1ps

module program_space_data_access
    import prog_access_pkg::*;
#(
    parameter int DATA_WIDTH = 16
)
(
    // Clock and reset
    input wire logic mclk,
    input wire logic reset_n,
    // Register port
    input wire logic [15:0] regAddr,
    input wire logic [15:0] regWriteData,
    input wire logic regWrite,
    input wire logic regRead,
    output logic [15:0] regReadData,
    // CPU request
    input wire logic cpuRequest,
    input wire logic [2:0] cpuOp,
    input wire logic byteMode,
    input wire logic [15:0] effectiveAddress,
    input wire logic [15:0] cpuWriteData,
    input wire logic isMove,
    input wire logic inRepeat,
    input wire logic repeatFirst,
    input wire logic repeatLast,
    input wire logic repeatIntExit,
    input wire logic repeatReentry,
    // CPU answer
    output logic cpuDone,
    output logic [15:0] cpuReadData,
    output logic windowHit,
    output logic [1:0] stallCycles,
    output logic busy,
    // Program flash
    output logic flashRequest,
    output logic flashWrite,
    output logic flashHighByte,
    output logic [23:0] flashAddr,
    output logic [15:0] flashWriteData,
    output logic configSpace,
    input wire logic [23:0] flashReadData
);

    // ------------------------------------------------------------
    // Elaboration check
    // ------------------------------------------------------------
    if (DATA_WIDTH != 16)
    begin : g_bad_width
        $error("DATA_WIDTH must be 16");
    end

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    typedef enum logic [2:0] {
        ST_IDLE,
        ST_TABLE_WAIT,
        ST_WINDOW_FETCH1,
        ST_WINDOW_FETCH2,
        ST_STRETCH
    } state_e;

    typedef struct packed {
        state_e state;
        logic [15:0] tablePage;
        logic [15:0] windowPage;
        logic [15:0] coreControl;
        logic [15:0] regReadData;
        logic cpuDone;
        logic [15:0] cpuReadData;
        logic windowHit;
        logic [1:0] stallCycles;
        logic [1:0] stretchLeft;
        logic busy;
        logic flashRequest;
        logic flashWrite;
        logic flashHighByte;
        logic [23:0] flashAddr;
        logic [15:0] flashWriteData;
        logic configSpace;
        logic [2:0] op;
        logic byteSel;
        logic byteMode;
    } state_s;

    state_s cur;
    state_s next_cur;
    logic [1:0] extraCycles;

    stretch_calc u_stretch (
        .isMove(isMove),
        .inRepeat(inRepeat),
        .repeatFirst(repeatFirst),
        .repeatLast(repeatLast),
        .repeatIntExit(repeatIntExit),
        .repeatReentry(repeatReentry),
        .extraCycles(extraCycles)
    );

    // ------------------------------------------------------------
    // Helpers
    // ------------------------------------------------------------
    // Word-aligned program address; the two spaces share it
    function automatic logic [23:0] table_address(input logic [15:0] page,
                                                 input logic [15:0] ea);
        table_address = {page[PAGE_WIDTH-1:0], ea[15:1], 1'b0};
    endfunction

    // Shape the flash word into read data per operation and mode
    function automatic logic [15:0] shape_read(input logic [2:0] op,
                                              input logic bmode,
                                              input logic bsel,
                                              input logic [23:0] word);
        shape_read = 16'h0000;
        if (op == OP_TABLE_READ_LOW)
        begin
            if (!bmode)
            begin
                shape_read = word[15:0];
            end
            else if (bsel)
            begin
                shape_read = {8'h00, word[15:8]};
            end
            else
            begin
                shape_read = {8'h00, word[7:0]};
            end
        end
        else if (op == OP_TABLE_READ_HIGH)
        begin
            if (!bmode || !bsel)
            begin
                shape_read = {8'h00, word[23:16]};
            end
            else
            begin
                shape_read = 16'h0000;
            end
        end
        else
        begin
            shape_read = word[15:0];
        end
    endfunction

    // ------------------------------------------------------------
    // Next state
    // ------------------------------------------------------------
    always_comb
    begin
        logic isTable;
        logic isWindow;
        isTable = 1'b0;
        isWindow = 1'b0;
        next_cur = cur;
        next_cur.cpuDone = 1'b0;
        next_cur.flashRequest = 1'b0;
        next_cur.regReadData = 16'h0000;

        // Register writes
        if (regWrite)
        begin
            if (regAddr == TABLE_PAGE_OFFSET)
            begin
                next_cur.tablePage = {8'h00, regWriteData[7:0]};
            end
            else if (regAddr == WINDOW_PAGE_OFFSET)
            begin
                next_cur.windowPage = {8'h00, regWriteData[7:0]};
            end
            else if (regAddr == CORE_CONTROL_OFFSET)
            begin
                next_cur.coreControl = regWriteData & CORE_CONTROL_MASK;
            end
        end

        // Register reads, unmapped reads return zero
        if (regRead)
        begin
            if (regAddr == TABLE_PAGE_OFFSET)
            begin
                next_cur.regReadData = cur.tablePage;
            end
            else if (regAddr == WINDOW_PAGE_OFFSET)
            begin
                next_cur.regReadData = cur.windowPage;
            end
            else if (regAddr == CORE_CONTROL_OFFSET)
            begin
                next_cur.regReadData = cur.coreControl;
            end
        end

        case (cur.state)
            ST_IDLE:
            begin
                isTable = cpuOp == OP_TABLE_READ_LOW || cpuOp == OP_TABLE_READ_HIGH
                    || cpuOp == OP_TABLE_WRITE_LOW || cpuOp == OP_TABLE_WRITE_HIGH;
                isWindow = cpuOp == OP_DATA_READ && effectiveAddress[DATA_ADDR_MSB]
                    && cur.coreControl[WINDOW_ENABLE_BIT];
                if (cpuRequest && isTable)
                begin
                    next_cur.state = ST_TABLE_WAIT;
                    next_cur.busy = 1'b1;
                    next_cur.op = cpuOp;
                    next_cur.byteMode = byteMode;
                    next_cur.byteSel = effectiveAddress[0];
                    next_cur.flashRequest = 1'b1;
                    next_cur.flashWrite = cpuOp == OP_TABLE_WRITE_LOW
                        || cpuOp == OP_TABLE_WRITE_HIGH;
                    next_cur.flashHighByte = cpuOp == OP_TABLE_READ_HIGH
                        || cpuOp == OP_TABLE_WRITE_HIGH;
                    next_cur.flashAddr = table_address(cur.tablePage, effectiveAddress);
                    next_cur.flashWriteData = cpuWriteData;
                    next_cur.configSpace = cur.tablePage[CONFIG_SPACE_BIT];
                    next_cur.windowHit = 1'b0;
                end
                else if (cpuRequest && isWindow)
                begin
                    next_cur.state = ST_WINDOW_FETCH1;
                    next_cur.busy = 1'b1;
                    next_cur.op = OP_DATA_READ;
                    next_cur.windowHit = 1'b1;
                    next_cur.flashRequest = 1'b1;
                    next_cur.flashWrite = 1'b0;
                    next_cur.flashHighByte = 1'b0;
                    next_cur.configSpace = 1'b0;
                    next_cur.flashAddr = {cur.windowPage[PAGE_WIDTH-1:0],
                        effectiveAddress[OFFSET_WIDTH-1:0], 1'b0};
                    next_cur.stallCycles = extraCycles;
                    next_cur.stretchLeft = extraCycles;
                end
                else if (cpuRequest)
                begin
                    // Ordinary data access is not ours; acknowledge at once
                    next_cur.cpuDone = 1'b1;
                    next_cur.cpuReadData = 16'h0000;
                    next_cur.windowHit = 1'b0;
                    next_cur.stallCycles = EXTRA_NONE;
                end
            end
            ST_TABLE_WAIT:
            begin
                next_cur.state = ST_IDLE;
                next_cur.busy = 1'b0;
                next_cur.cpuDone = 1'b1;
                next_cur.stallCycles = EXTRA_NONE;
                next_cur.cpuReadData = cur.flashWrite ? 16'h0000
                    : shape_read(cur.op, cur.byteMode, cur.byteSel, flashReadData);
            end
            ST_WINDOW_FETCH1:
            begin
                // Second fetch is the reason a window read adds a cycle
                next_cur.state = ST_WINDOW_FETCH2;
                next_cur.flashRequest = 1'b1;
            end
            ST_WINDOW_FETCH2:
            begin
                next_cur.cpuReadData = shape_read(OP_DATA_READ, 1'b0, 1'b0,
                    flashReadData);
                if (cur.stretchLeft > 2'h1)
                begin
                    next_cur.state = ST_STRETCH;
                    next_cur.stretchLeft = cur.stretchLeft - 2'h1;
                end
                else
                begin
                    next_cur.state = ST_IDLE;
                    next_cur.busy = 1'b0;
                    next_cur.cpuDone = 1'b1;
                end
            end
            ST_STRETCH:
            begin
                next_cur.state = ST_IDLE;
                next_cur.busy = 1'b0;
                next_cur.cpuDone = 1'b1;
                next_cur.stretchLeft = 2'h0;
            end
            default:
            begin
                next_cur.state = ST_IDLE;
            end
        endcase
    end

    // ------------------------------------------------------------
    // Registers
    // ------------------------------------------------------------
    always_ff @(posedge mclk)
    begin
        if (!reset_n)
        begin
            cur <= '0;
            cur.state <= ST_IDLE;
            cur.tablePage <= TABLE_PAGE_RESET;
            cur.windowPage <= WINDOW_PAGE_RESET;
            cur.coreControl <= CORE_CONTROL_RESET;
        end
        else
        begin
            cur <= next_cur;
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign regReadData = cur.regReadData;
    assign cpuDone = cur.cpuDone;
    assign cpuReadData = cur.cpuReadData;
    assign windowHit = cur.windowHit;
    assign stallCycles = cur.stallCycles;
    assign busy = cur.busy;
    assign flashRequest = cur.flashRequest;
    assign flashWrite = cur.flashWrite;
    assign flashHighByte = cur.flashHighByte;
    assign flashAddr = cur.flashAddr;
    assign flashWriteData = cur.flashWriteData;
    assign configSpace = cur.configSpace;

endmodule

/* File: verilog/stretch_calc.sv */
// Extra-cycle calculator for instructions that read through the window.
// Assumes repeat-loop status inputs are stable while a request is raised.
`timescale 1ns/1ps

module stretch_calc
    import prog_access_pkg::*;
(
    // Instruction context
    input wire logic isMove,
    input wire logic inRepeat,
    input wire logic repeatFirst,
    input wire logic repeatLast,
    input wire logic repeatIntExit,
    input wire logic repeatReentry,
    // Result
    output logic [1:0] extraCycles
);

    always_comb
    begin
        if (!inRepeat)
        begin
            extraCycles = isMove ? EXTRA_MOVE : EXTRA_OTHER;
        end
        else if (repeatFirst || repeatLast || repeatIntExit || repeatReentry)
        begin
            extraCycles = EXTRA_OTHER;
        end
        else
        begin
            extraCycles = EXTRA_NONE;
        end
    end

endmodule
